// >>> core/mts_pkg.sv
// Shared constants and types of the measurement trigger sequencer.
// Assumes a 25 MHz device clock; programmable times are given in milliseconds, the aperture in clock cycles.
package mts_pkg;
	// Clock rate and millisecond tick
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;
	// Widths
	localparam int MS_W = 14;
	localparam int CYC_W = 14;
	localparam int SAMPLE_W = 16;
	localparam int APER_W = 16;
	localparam int PART_W = SAMPLE_W + APER_W + 1;
	localparam int AVG_DEPTH = 16;
	localparam int AVG_W = 5;
	localparam int IDX_W = 4;
	localparam int SUM_W = PART_W + AVG_W;
	// Artificial trigger timeout, 0.1 s to 5.0 s, reset 2.0 s
	localparam logic [MS_W-1:0] ATRIG_TIMEOUT_MIN_MS = 14'h0064;
	localparam logic [MS_W-1:0] ATRIG_TIMEOUT_MAX_MS = 14'h1388;
	localparam logic [MS_W-1:0] ATRIG_TIMEOUT_RST_MS = 14'h07d0;
	// Trigger delay, -5.0 s to 10.0 s, reset 0.0 s
	localparam logic signed [MS_W:0] TRIG_DELAY_MIN_MS = -15'sh1388;
	localparam logic signed [MS_W:0] TRIG_DELAY_MAX_MS = 15'sh2710;
	localparam logic signed [MS_W:0] TRIG_DELAY_RST_MS = 15'sh0000;
	// Dropout time, 0.00 s to 10.00 s, reset 0.00 s
	localparam logic [MS_W-1:0] DROPOUT_MAX_MS = 14'h2710;
	localparam logic [MS_W-1:0] DROPOUT_RST_MS = 14'h0000;
	// Cycle count, 1 to 8192
	localparam logic [CYC_W-1:0] CYCLE_MIN = 14'h0001;
	localparam logic [CYC_W-1:0] CYCLE_MAX = 14'h2000;
	// Settling delay used when auto delay is on
	localparam logic [MS_W-1:0] AUTO_SETTLE_MS = 14'h000a;

	typedef enum logic {
		MTS_TERM_REPEAT,
		MTS_TERM_MOVING
	} mts_term_t;

	typedef enum logic [1:0] {
		MTS_ST_IDLE,
		MTS_ST_WAIT,
		MTS_ST_DELAY,
		MTS_ST_MEAS
	} mts_state_t;

	typedef struct packed {
		mts_term_t result_termination_select;
		logic [AVG_W-1:0] avg_count;
		logic [CYC_W-1:0] cycle_count;
		logic continuous;
		logic sync_hold_enable;
		logic internal_source;
		logic auto_trigger_enable;
		logic [MS_W-1:0] auto_trigger_timeout;
		logic signed [MS_W:0] trigger_delay;
		logic auto_delay_enable;
		logic [MS_W-1:0] retrigger_dropout_time;
		logic [APER_W-1:0] aperture_cycles;
	} mts_cfg_t;

	typedef struct packed {
		logic signed [SUM_W-1:0] sum;
		logic [AVG_W-1:0] count;
		logic settled;
		logic artificial;
	} mts_result_t;
endpackage : mts_pkg

// >>> core/mts_sequencer.sv
// Measurement trigger sequencer: trigger states, chopper timing, averaging and result release.
// Assumes configuration is held steady by the host while a measurement runs and that the
// internal level comparator runs on ref_clk_i; the external trigger pin is asynchronous.
//
// Behaviour
// [RULE1] Repeat mode releases one averaged result only after avg_count measurements.
// [RULE2] Moving mode releases a result after every measurement, averaging the latest ones.
// [RULE3] A measurement is a noninverted then an inverted chopper phase, one aperture each.
// [RULE4] With sync hold on, the sync output is high while a measurement cycle runs.
// [RULE5] In moving mode results are flagged settled once avg_count measurements are in.
// [RULE6] The sequencer returns to idle once the cycle count has been performed.
// [RULE7] A single measurement runs the same sequence as continuous, without restart.
// [RULE8] The artificial trigger timeout spans 0.1 s to 5.0 s and acts only with auto trigger.
// [RULE9] With auto trigger on, a missing trigger after the timeout makes an artificial one.
// [RULE10] Measurements started by artificial triggers are tallied since auto trigger was enabled.
// [RULE11] The cycle count spans 1 to 8192 and each result restarts the next cycle internally.
// [RULE12] The trigger delay, -5.0 s to 10.0 s, stands between trigger and integration; the code treats negative delays as zero.
// [RULE13] Auto delay waits a settling time, or the manual delay when that is longer.
// [RULE14] The internal source rearms only after the level stayed low for the dropout time.
// [RULE15] States are idle, waiting for trigger and measuring, idle from reset; the code adds a delay state between waiting and measuring.
// [RULE16] Moving mode keeps a circular history no deeper than avg_count, averaging what exists.
`timescale 1ns/1ns
`default_nettype none
module mts_sequencer import mts_pkg::*; #(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire mts_cfg_t cfg_i,
	input wire logic start_single_i,
	input wire logic abort_i,
	input wire logic ext_trigger_i,
	input wire logic level_above_i,
	input wire logic signed [SAMPLE_W-1:0] sample_i,
	output mts_state_t state_o,
	output logic chop_invert_o,
	output logic trigger_sync_o,
	output logic result_valid_o,
	output mts_result_t result_o,
	output logic [CYC_W-1:0] auto_trigger_tally_o
);
	mts_state_t state_r, state_nxt;
	logic [31:0] tick_cnt_r;
	logic tick_r;
	logic ext_s1_r, ext_s2_r, ext_s3_r, ext_lvl_r, ext_evt_r;
	logic lvl_prev_r;
	logic [MS_W-1:0] low_ms_r;
	logic [MS_W-1:0] timer_ms_r;
	logic cont_prev_r, aten_prev_r;
	logic [APER_W-1:0] aper_cnt_r;
	logic phase_r, phase_nxt;
	logic signed [PART_W-1:0] acc_r;
	logic part_done_r;
	logic signed [PART_W-1:0] part_r;
	logic signed [SUM_W-1:0] rep_sum_r, mov_sum_r;
	logic [AVG_W-1:0] rep_n_r, filled_r;
	logic [IDX_W-1:0] wr_idx_r;
	logic signed [PART_W-1:0] hist_r [AVG_DEPTH];
	logic [CYC_W-1:0] cyc_done_r;
	logic busy_r, art_r;
	logic trig_evt, int_evt, art_evt, release_now, restart, cycles_met, start_req;
	logic [AVG_W-1:0] avg_eff;
	logic [CYC_W-1:0] cyc_eff;
	logic [MS_W-1:0] tmo_eff, dly_manual, dly_eff;
	logic [APER_W-1:0] aper_eff;

	// Clamp host settings into their legal ranges
	always_comb begin
		avg_eff = cfg_i.avg_count;
		if (avg_eff == '0)
			avg_eff = AVG_W'(1);
		else if (avg_eff > AVG_W'(AVG_DEPTH))
			avg_eff = AVG_W'(AVG_DEPTH);
		// [RULE11] cycle count range
		cyc_eff = cfg_i.cycle_count;
		if (cyc_eff < CYCLE_MIN)
			cyc_eff = CYCLE_MIN;
		else if (cyc_eff > CYCLE_MAX)
			cyc_eff = CYCLE_MAX;
		// [RULE8] timeout range
		tmo_eff = cfg_i.auto_trigger_timeout;
		if (tmo_eff < ATRIG_TIMEOUT_MIN_MS)
			tmo_eff = ATRIG_TIMEOUT_MIN_MS;
		else if (tmo_eff > ATRIG_TIMEOUT_MAX_MS)
			tmo_eff = ATRIG_TIMEOUT_MAX_MS;
		// [RULE12] delay range; a negative delay cannot reach back, so it acts as zero
		if (cfg_i.trigger_delay <= 15'sh0000)
			dly_manual = '0;
		else if (cfg_i.trigger_delay > TRIG_DELAY_MAX_MS)
			dly_manual = TRIG_DELAY_MAX_MS[MS_W-1:0];
		else
			dly_manual = cfg_i.trigger_delay[MS_W-1:0];
		// [RULE13] longer of settle and manual delay
		dly_eff = dly_manual;
		if (cfg_i.auto_delay_enable && AUTO_SETTLE_MS > dly_manual)
			dly_eff = AUTO_SETTLE_MS;
		aper_eff = (cfg_i.aperture_cycles == '0) ? APER_W'(1) : cfg_i.aperture_cycles;
	end

	// Millisecond tick; long count kept as a parameter so simulation can shorten it
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r <= 1'b0;
		end else if (tick_cnt_r >= TICK_LEN - 1) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
			tick_r <= 1'b0;
		end
	end

	// External pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
			ext_lvl_r <= 1'b0;
			ext_evt_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_trigger_i;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			ext_evt_r <= 1'b0;
			if (ext_s2_r == ext_s3_r) begin
				ext_lvl_r <= ext_s3_r;
				ext_evt_r <= ext_s3_r & ~ext_lvl_r;
			end
		end
	end

	// [RULE14] dropout rearm: count time spent below threshold, restart on every crossing
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lvl_prev_r <= 1'b0;
			low_ms_r <= DROPOUT_RST_MS;
		end else begin
			lvl_prev_r <= level_above_i;
			if (level_above_i)
				low_ms_r <= '0;
			else if (tick_r && low_ms_r != {MS_W{1'b1}})
				low_ms_r <= low_ms_r + MS_W'(1);
		end
	end

	assign int_evt = level_above_i & ~lvl_prev_r &
		(low_ms_r >= ((cfg_i.retrigger_dropout_time > DROPOUT_MAX_MS) ?
		DROPOUT_MAX_MS : cfg_i.retrigger_dropout_time));
	assign trig_evt = cfg_i.internal_source ? int_evt : ext_evt_r;
	// [RULE9] artificial trigger after the timeout with no real event
	assign art_evt = cfg_i.auto_trigger_enable && !trig_evt && timer_ms_r >= tmo_eff;
	assign start_req = start_single_i | (cfg_i.continuous & ~cont_prev_r);
	assign cycles_met = (cyc_done_r + CYC_W'(1)) >= cyc_eff;

	// Release decision at the end of each measurement
	always_comb begin
		release_now = 1'b0;
		if (part_done_r) begin
			if (cfg_i.result_termination_select == MTS_TERM_MOVING)
				release_now = 1'b1;
			else
				release_now = (rep_n_r + AVG_W'(1)) >= avg_eff;
		end
	end
	// [RULE11] internal restart until the cycle count is done
	// [RULE7] single runs stop at the count, continuous runs go on
	assign restart = !release_now || cfg_i.continuous || !cycles_met;

	// [RULE15] trigger state machine
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			MTS_ST_IDLE: begin
				if (start_req)
					state_nxt = MTS_ST_WAIT;
			end
			MTS_ST_WAIT: begin
				if (trig_evt || art_evt)
					state_nxt = MTS_ST_DELAY;
			end
			MTS_ST_DELAY: begin
				// [RULE12] integration starts after the delay
				if (timer_ms_r >= dly_eff)
					state_nxt = MTS_ST_MEAS;
			end
			MTS_ST_MEAS: begin
				// [RULE6] back to idle when the count is reached, unless continuous
				if (part_done_r)
					state_nxt = restart ? MTS_ST_WAIT : MTS_ST_IDLE;
			end
		endcase
		if (cont_prev_r && !cfg_i.continuous)
			state_nxt = MTS_ST_IDLE;
		else if (abort_i && state_r != MTS_ST_IDLE)
			state_nxt = cfg_i.continuous ? MTS_ST_WAIT : MTS_ST_IDLE;
	end

	// State, millisecond timer and mode edges
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= MTS_ST_IDLE;
			timer_ms_r <= '0;
			cont_prev_r <= 1'b0;
			aten_prev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cont_prev_r <= cfg_i.continuous;
			aten_prev_r <= cfg_i.auto_trigger_enable;
			if (state_nxt != state_r)
				timer_ms_r <= '0;
			else if (tick_r && timer_ms_r != {MS_W{1'b1}})
				timer_ms_r <= timer_ms_r + MS_W'(1);
		end
	end

	// [RULE3] next chopper phase; the pin registers it so it matches the integrator phase and every sample carries its sign
	assign phase_nxt = (state_r == MTS_ST_MEAS && !part_done_r && !abort_i) ?
		(phase_r ^ (aper_cnt_r + APER_W'(1) >= aper_eff)) : 1'b0;

	// [RULE3] two chopper phases of one aperture each; the inverted phase is subtracted
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aper_cnt_r <= '0;
			phase_r <= 1'b0;
			acc_r <= '0;
			part_done_r <= 1'b0;
			part_r <= '0;
		end else begin
			part_done_r <= 1'b0;
			if (state_r != MTS_ST_MEAS || part_done_r || abort_i) begin
				aper_cnt_r <= '0;
				phase_r <= 1'b0;
				acc_r <= '0;
			end else if (phase_r)
				acc_r <= acc_r - PART_W'(sample_i);
			else
				acc_r <= acc_r + PART_W'(sample_i);
			if (state_r == MTS_ST_MEAS && !part_done_r && !abort_i) begin
				if (aper_cnt_r + APER_W'(1) >= aper_eff) begin
					aper_cnt_r <= '0;
					phase_r <= ~phase_r;
					if (phase_r) begin
						part_done_r <= 1'b1;
						part_r <= acc_r - PART_W'(sample_i);
					end
				end else
					aper_cnt_r <= aper_cnt_r + APER_W'(1);
			end
		end
	end

	// [RULE1] repeat-mode accumulator, emptied at each release or new start
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rep_sum_r <= '0;
			rep_n_r <= '0;
		end else if (start_req && state_r == MTS_ST_IDLE || release_now || abort_i) begin
			rep_sum_r <= '0;
			rep_n_r <= '0;
		end else if (part_done_r) begin
			rep_sum_r <= rep_sum_r + SUM_W'(part_r);
			rep_n_r <= rep_n_r + AVG_W'(1);
		end
	end

	// [RULE16] circular history in moving mode, depth set by avg_count
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mov_sum_r <= '0;
			filled_r <= '0;
			wr_idx_r <= '0;
		end else if (start_req && state_r == MTS_ST_IDLE) begin
			mov_sum_r <= '0;
			filled_r <= '0;
			wr_idx_r <= '0;
		end else if (part_done_r && cfg_i.result_termination_select == MTS_TERM_MOVING) begin
			// [RULE2] drop the oldest once full, otherwise average what is there
			if (filled_r >= avg_eff)
				mov_sum_r <= mov_sum_r + SUM_W'(part_r) - SUM_W'(hist_r[wr_idx_r]);
			else begin
				mov_sum_r <= mov_sum_r + SUM_W'(part_r);
				filled_r <= filled_r + AVG_W'(1);
			end
			wr_idx_r <= ({1'b0, wr_idx_r} + AVG_W'(1) >= avg_eff) ? '0 : wr_idx_r + IDX_W'(1);
		end
	end

	// History storage, one entry per slot
	generate
		for (genvar i = 0; i < AVG_DEPTH; i++) begin : g_hist
			always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
				if (!reset_n_i)
					hist_r[i] <= '0;
				else if (part_done_r && wr_idx_r == IDX_W'(i))
					hist_r[i] <= part_r;
			end
		end
	endgenerate

	// Result register: sum and its count, the host divides
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			result_valid_o <= 1'b0;
			result_o <= '0;
		end else begin
			result_valid_o <= release_now;
			if (release_now && cfg_i.result_termination_select == MTS_TERM_MOVING) begin
				// [RULE5] settled once the history holds avg_count entries
				if (filled_r >= avg_eff) begin
					result_o.sum <= mov_sum_r + SUM_W'(part_r) - SUM_W'(hist_r[wr_idx_r]);
					result_o.count <= avg_eff;
					result_o.settled <= 1'b1;
				end else begin
					result_o.sum <= mov_sum_r + SUM_W'(part_r);
					result_o.count <= filled_r + AVG_W'(1);
					result_o.settled <= (filled_r + AVG_W'(1)) >= avg_eff;
				end
				result_o.artificial <= art_r;
			end else if (release_now) begin
				result_o.sum <= rep_sum_r + SUM_W'(part_r);
				result_o.count <= avg_eff;
				result_o.settled <= 1'b1;
				result_o.artificial <= art_r;
			end
		end
	end

	// Cycle counter, cycle-busy flag and artificial-start flag
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cyc_done_r <= '0;
			busy_r <= 1'b0;
			art_r <= 1'b0;
		end else begin
			if (state_r == MTS_ST_IDLE)
				cyc_done_r <= '0;
			else if (release_now)
				cyc_done_r <= cyc_done_r + CYC_W'(1);
			if (state_nxt == MTS_ST_IDLE || release_now)
				busy_r <= 1'b0;
			else if (state_r == MTS_ST_WAIT && state_nxt == MTS_ST_DELAY)
				busy_r <= 1'b1;
			if (state_r == MTS_ST_WAIT && state_nxt == MTS_ST_DELAY)
				art_r <= art_evt;
		end
	end

	// [RULE10] artificial-start tally, cleared when auto trigger is switched on
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			auto_trigger_tally_o <= '0;
		else if (cfg_i.auto_trigger_enable && !aten_prev_r)
			auto_trigger_tally_o <= '0;
		else if (state_r == MTS_ST_WAIT && state_nxt == MTS_ST_DELAY && art_evt &&
			auto_trigger_tally_o != {CYC_W{1'b1}})
			auto_trigger_tally_o <= auto_trigger_tally_o + CYC_W'(1);
	end

	// Registered pin outputs; sync lags the cycle flag by one clock
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_o <= MTS_ST_IDLE;
			chop_invert_o <= 1'b0;
			trigger_sync_o <= 1'b0;
		end else begin
			state_o <= state_r;
			// [RULE3] chop pin aligned with phase
			chop_invert_o <= phase_nxt;
			// [RULE4] sync high through the cycle
			trigger_sync_o <= cfg_i.sync_hold_enable & busy_r;
		end
	end
endmodule : mts_sequencer
`default_nettype wire

// >>> verification/mts_monitor.sv
// Port checker of the measurement trigger sequencer.
// Sees only the sequencer ports; bound to it at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module mts_monitor import mts_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire mts_cfg_t cfg_i,
	input wire logic start_single_i,
	input wire mts_state_t state_o,
	input wire logic chop_invert_o,
	input wire logic trigger_sync_o,
	input wire logic result_valid_o,
	input wire mts_result_t result_o,
	input wire logic [CYC_W-1:0] auto_trigger_tally_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_rep_cnt;
		result_valid_o && cfg_i.result_termination_select == MTS_TERM_REPEAT
			|-> result_o.count == cfg_i.avg_count;
	endproperty
	a_rep_cnt: assert property (p_rep_cnt) else $error("repeat count wrong");
	property p_mov_cnt;
		result_valid_o && cfg_i.result_termination_select == MTS_TERM_MOVING
			|-> result_o.count != 0 && result_o.count <= cfg_i.avg_count;
	endproperty
	a_mov_cnt: assert property (p_mov_cnt) else $error("moving depth wrong");
	property p_settled;
		result_valid_o && cfg_i.result_termination_select == MTS_TERM_MOVING
			|-> result_o.settled == (result_o.count == cfg_i.avg_count);
	endproperty
	a_settled: assert property (p_settled) else $error("settled flag wrong");
	property p_hold;
		!result_valid_o |-> $stable(result_o);
	endproperty
	a_hold: assert property (p_hold) else $error("result moved");
	property p_pulse;
		result_valid_o |=> !result_valid_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("valid too long");
	property p_chop;
		result_valid_o |-> $past(chop_invert_o, 2) || $past(chop_invert_o, 3);
	endproperty
	a_chop: assert property (p_chop) else $error("no inverted phase");
	property p_sync;
		(state_o == MTS_ST_MEAS && cfg_i.sync_hold_enable)[*2] |-> trigger_sync_o;
	endproperty
	a_sync: assert property (p_sync) else $error("sync low in measure");
	// delay stage between trigger and measure
	property p_dly;
		state_o == MTS_ST_WAIT |=> state_o != MTS_ST_MEAS;
	endproperty
	a_dly: assert property (p_dly) else $error("skipped delay stage");
	property p_art;
		result_valid_o && result_o.artificial |-> cfg_i.auto_trigger_enable;
	endproperty
	a_art: assert property (p_art) else $error("artificial without auto");
	property p_tally;
		$rose(cfg_i.auto_trigger_enable) |-> ##[1:2] auto_trigger_tally_o == 0;
	endproperty
	a_tally: assert property (p_tally) else $error("tally not cleared");
	property p_start;
		state_o == MTS_ST_IDLE && start_single_i && !cfg_i.continuous
			|-> ##2 state_o == MTS_ST_WAIT;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
endmodule : mts_monitor

bind mts_sequencer mts_monitor u_mts_monitor (
	.ref_clk_i(ref_clk_i),
	.reset_n_i(reset_n_i),
	.cfg_i(cfg_i),
	.start_single_i(start_single_i),
	.state_o(state_o),
	.chop_invert_o(chop_invert_o),
	.trigger_sync_o(trigger_sync_o),
	.result_valid_o(result_valid_o),
	.result_o(result_o),
	.auto_trigger_tally_o(auto_trigger_tally_o)
);
`default_nettype wire

// >>> verification/mts_sig_src.sv
// Model of the signal and trigger source in front of the sequencer.
// Assumes the sequencer state and chopper outputs are visible to it.
`timescale 1ns/1ns
`default_nettype none
module mts_sig_src import mts_pkg::*; #(
	parameter logic signed [SAMPLE_W-1:0] AMP = 16'sh0005
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic fire_en_i,
	input wire mts_state_t state_i,
	input wire logic chop_i,
	output logic ext_trig_o,
	output logic level_above_o,
	output logic signed [SAMPLE_W-1:0] sample_o
);
	logic [2:0] gap_r;
	// Three clocks high, five low, so one edge per wait and sync stages settle
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gap_r <= 3'h0;
		end else if (gap_r != 3'h0 || (fire_en_i && state_i == MTS_ST_WAIT)) begin
			gap_r <= gap_r + 3'h1;
		end
	end
	assign ext_trig_o = (gap_r != 3'h0) && !gap_r[2];
	assign level_above_o = ext_trig_o;
	assign sample_o = chop_i ? -AMP : AMP;
endmodule : mts_sig_src
`default_nettype wire

// >>> verification/mts_sequencer_tb_top.sv
// Self-checking bench of the sequencer driven by the source model.
// Uses a 4-clock millisecond tick so timeouts stay short.
`timescale 1ns/1ns
`default_nettype none
module mts_sequencer_tb_top import mts_pkg::*; ;
	localparam int PER = 20; // 2 phases x 2-cycle aperture x amplitude 5
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	mts_cfg_t cfg = '0;
	logic start = 1'b0;
	logic abort = 1'b0;
	logic fire = 1'b0;
	wire logic ext_trig, level_above, chop, sync, valid;
	wire logic signed [SAMPLE_W-1:0] sample;
	wire mts_state_t state;
	wire mts_result_t result;
	wire logic [CYC_W-1:0] tally;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	mts_result_t res[$];

	mts_sequencer #(.TICK_LEN(4)) u_mts_sequencer (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg),
		.start_single_i(start), .abort_i(abort), .ext_trigger_i(ext_trig),
		.level_above_i(level_above), .sample_i(sample), .state_o(state),
		.chop_invert_o(chop), .trigger_sync_o(sync), .result_valid_o(valid),
		.result_o(result), .auto_trigger_tally_o(tally));
	mts_sig_src u_mts_sig_src (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .fire_en_i(fire),
		.state_i(state), .chop_i(chop), .ext_trig_o(ext_trig),
		.level_above_o(level_above), .sample_o(sample));

	// Clock
	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	// Collect results mid-cycle, away from the launching edge
	always @(negedge ref_clk_i) begin
		if (valid === 1'b1) res.push_back(result);
	end
	// Hang guard
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			tally_and_finish();
		end
	end

	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk

	function automatic mts_cfg_t base(input mts_term_t t, input int avg, input int n);
		mts_cfg_t c;
		c = '0;
		c.result_termination_select = t;
		c.avg_count = AVG_W'(avg);
		c.cycle_count = CYC_W'(n);
		c.sync_hold_enable = 1'b1;
		c.auto_trigger_timeout = ATRIG_TIMEOUT_MIN_MS;
		c.aperture_cycles = 16'h0002;
		return c;
	endfunction : base

	// Single start, then wait for idle under a bound
	task automatic run(input mts_cfg_t c, input int lim);
		int n;
		res.delete();
		cfg <= c;
		fire <= !c.auto_trigger_enable;
		@(posedge ref_clk_i);
		start <= 1'b1;
		@(posedge ref_clk_i);
		start <= 1'b0;
		n = 0;
		repeat (3) @(negedge ref_clk_i);
		while (state !== MTS_ST_IDLE && n < lim) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk(n < lim, "no return to idle");
		@(posedge ref_clk_i);
	endtask : run

	task automatic t_repeat();
		run(base(MTS_TERM_REPEAT, 2, 1), 2000);
		chk(res.size() == 1, "repeat result count");
		chk(res[0].sum === SUM_W'(2 * PER), "repeat sum");
		chk(res[0].count === AVG_W'(2), "repeat depth");
		$display("test repeat done");
	endtask : t_repeat

	task automatic t_moving();
		int e;
		run(base(MTS_TERM_MOVING, 2, 3), 3000);
		chk(res.size() == 3, "moving result count");
		for (int i = 0; i < 3; i++) begin
			e = (i == 0) ? 1 : 2;
			chk(res[i].sum === SUM_W'(e * PER), "moving sum");
			chk(res[i].count === AVG_W'(e), "moving depth");
			chk(res[i].settled === (e == 2), "settled flag");
		end
		$display("test moving done");
	endtask : t_moving

	task automatic t_auto();
		mts_cfg_t c;
		c = base(MTS_TERM_REPEAT, 1, 1);
		c.auto_trigger_enable = 1'b1;
		run(c, 3000);
		chk(res.size() == 1, "auto result count");
		chk(res[0].artificial === 1'b1, "artificial flag");
		chk(tally === CYC_W'(1), "auto tally");
		$display("test auto done");
	endtask : t_auto

	// Internal level source, zero dropout, two cycles
	task automatic t_int();
		mts_cfg_t c;
		c = base(MTS_TERM_MOVING, 1, 2);
		c.internal_source = 1'b1;
		run(c, 3000);
		chk(res.size() == 2, "internal result count");
		chk(res[1].sum === SUM_W'(PER), "internal sum");
		$display("test internal done");
	endtask : t_int

	// Abort while waiting for a trigger in a single run
	task automatic t_abort();
		int n;
		cfg <= base(MTS_TERM_REPEAT, 1, 1);
		fire <= 1'b0;
		@(posedge ref_clk_i);
		start <= 1'b1;
		@(posedge ref_clk_i);
		start <= 1'b0;
		n = 0;
		while (state !== MTS_ST_WAIT && n < 20) begin
			@(posedge ref_clk_i);
			n++;
		end
		chk(state === MTS_ST_WAIT, "start not waiting");
		abort <= 1'b1;
		@(posedge ref_clk_i);
		abort <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		chk(state === MTS_ST_IDLE, "abort not idle");
		chk(sync === 1'b0, "sync high after abort");
		$display("test abort done");
	endtask : t_abort

	task automatic t_cont();
		mts_cfg_t c;
		int n;
		c = base(MTS_TERM_MOVING, 1, 1);
		c.continuous = 1'b1;
		res.delete();
		fire <= 1'b1;
		cfg <= c;
		n = 0;
		while (res.size() < 3 && n < 3000) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk(res.size() >= 3, "continuous did not repeat");
		@(posedge ref_clk_i);
		c.continuous = 1'b0;
		cfg <= c;
		repeat (4) @(negedge ref_clk_i);
		chk(state === MTS_ST_IDLE, "continuous off not idle");
		$display("test continuous done");
	endtask : t_cont

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		@(posedge ref_clk_i);
		t_repeat();
		t_moving();
		t_auto();
		t_int();
		t_abort();
		t_cont();
		tally_and_finish();
	end
endmodule : mts_sequencer_tb_top
`default_nettype wire
